// ### pkg/pbsl_pkg.sv
// pbsl_pkg: opcode fields, class codes and constants for the peripheral-bus
// and short-literal execution block.
// assumes: 16-bit instruction words, one processor clock.
package pbsl_pkg;

    localparam int WORD_W = 16;
    localparam int ADDR_W = 5;
    localparam int OP_W   = 4;

    // ***********************************************************
    // instruction field positions
    // ***********************************************************
    localparam int OPC_HI_MSB = 15;
    localparam int OPC_HI_LSB = 12;
    localparam int OP_MSB     = 11;
    localparam int OP_LSB     = 8;
    localparam int INV_BIT    = 8;
    localparam int SUB_MSB    = 7;
    localparam int SUB_LSB    = 6;
    localparam int RET_BIT    = 5;
    localparam int FLD_MSB    = 4;
    localparam int FLD_LSB    = 0;

    localparam logic [3:0] CLASS_11 = 4'hb;
    // sub-field 7:6 selects bus access (00, 10, 11) or short literal (01)
    localparam logic [1:0] SUB_RD   = 2'h0;
    localparam logic [1:0] SUB_LIT  = 2'h1;
    localparam logic [1:0] SUB_WR   = 2'h2;
    localparam logic [1:0] SUB_XTRA = 2'h3;
    // op field 11:9 all zero with bit 8 as invert: plain forms
    localparam logic [2:0] OP_PLAIN = 3'h0;
    // under sub-field 11: op 000 pops after the store, op 001 reads and drops
    localparam logic [2:0] OP_DROP  = 3'h1;

    // ***********************************************************
    // predefined bus addresses under the plain store form (sub-field 10, op 000, bit 8 clear); the external base applies to every access
    // ***********************************************************
    localparam logic [4:0] ADDR_SEL_CODE = 5'h0d;
    localparam logic [4:0] ADDR_SEL_DATA = 5'h0e;
    localparam logic [4:0] ADDR_SWI_SET  = 5'h0b;
    localparam logic [4:0] ADDR_SWI_CLR  = 5'h0c;
    localparam logic [4:0] ADDR_EXT_BASE = 5'h18;

    localparam logic [3:0] SWI_LEVEL = 4'hd;

    localparam logic       PAGE_SEL_RST = 1'b0;
    localparam logic       SWI_RST      = 1'b0;
    localparam logic [15:0] WORD_RST    = 16'h0000;

    typedef enum logic [2:0] {
        PBSL_NONE     = 3'b000,
        PBSL_READ_ALU = 3'b001,
        PBSL_FETCH    = 3'b010,
        PBSL_LIT      = 3'b011,
        PBSL_STORE    = 3'b100,
        PBSL_POP      = 3'b101,
        PBSL_DROP     = 3'b110
    } pbsl_kind_t;

endpackage

// ### design/pbsl_exec.sv
// pbsl_exec: executes peripheral-bus access and short-literal instructions
// on the top/next stack registers in one cycle each.
// assumes: the core presents one decoded-ready instruction per cycle with
// instr_valid; the ALU function table lives outside and answers combinationally.
`timescale 1ns/100ps
`default_nettype none

module pbsl_exec
    import pbsl_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              instr_valid,
    input  wire logic [15:0]       instr,
    input  wire logic [15:0]       bus_rdata,
    input  wire logic [15:0]       alu_result,
    input  wire logic [15:0]       stack_pop_data,
    output logic      [15:0]       top,
    output logic      [15:0]       next,
    output logic      [15:0]       alu_a,
    output logic      [15:0]       alu_b,
    output logic      [3:0]        alu_func,
    output logic      [4:0]        bus_addr,
    output logic      [15:0]       bus_wdata,
    output logic                   bus_rd,
    output logic                   bus_wr,
    output logic                   bus_ext,
    output logic                   stack_push,
    output logic      [15:0]       stack_push_data,
    output logic                   stack_pop,
    output logic                   sub_return,
    output logic                   page_select_bit,
    output logic                   soft_irq_request,
    output logic      [3:0]        soft_irq_level
);

    // ***********************************************************
    // state
    // ***********************************************************
    typedef struct packed {
        logic [15:0] top;
        logic [15:0] next;
        logic [4:0]  bus_addr;
        logic [15:0] bus_wdata;
        logic        bus_rd;
        logic        bus_wr;
        logic        bus_ext;
        logic        stack_push;
        logic [15:0] stack_push_data;
        logic        stack_pop;
        logic        sub_return;
        logic        page_select_bit;
        logic        soft_irq_request;
    } pbsl_state_t;

    pbsl_state_t st;
    pbsl_state_t next_st;

    logic [1:0]  sub;
    logic        inv;
    logic        is_cls;
    logic [4:0]  fld;
    logic [15:0] lit;
    logic [15:0] lit_val;
    logic [15:0] rd_val;
    pbsl_kind_t  kind;

    assign sub    = instr[SUB_MSB:SUB_LSB];
    assign inv    = instr[INV_BIT];
    assign fld    = instr[FLD_MSB:FLD_LSB];
    assign is_cls = instr_valid && (instr[OPC_HI_MSB:OPC_HI_LSB] == CLASS_11);
    assign lit     = {11'h000, fld};
    assign lit_val = inv ? ~lit : lit;
    assign rd_val  = inv ? ~bus_rdata : bus_rdata;

    // the alu sees live operands; its function comes straight from the op field
    // shared alu function select
    assign alu_func = instr[OP_MSB:OP_LSB];
    assign alu_a    = st.top;
    assign alu_b    = (sub == SUB_LIT) ? lit : bus_rdata;

    always_comb begin
        kind = PBSL_NONE;
        if (is_cls) begin
            if (sub == SUB_LIT) begin
                kind = PBSL_LIT;
            end else if (sub == SUB_WR) begin
                kind = (instr[11:9] == OP_PLAIN) ? PBSL_STORE : PBSL_READ_ALU;
            end else if (sub == SUB_RD) begin
                kind = PBSL_FETCH;
            end else if (instr[11:9] == OP_PLAIN) begin
                kind = PBSL_POP;
            end else if (instr[11:9] == OP_DROP) begin
                kind = PBSL_DROP;
            end
        end
    end

    // ***********************************************************
    // next-state logic
    // ***********************************************************
    always_comb begin
        next_st = st;
        next_st.bus_rd = 1'b0;
        next_st.bus_wr = 1'b0;
        next_st.stack_push = 1'b0;
        next_st.stack_pop  = 1'b0;
        next_st.sub_return = 1'b0;
        next_st.bus_addr   = fld;
        next_st.bus_ext    = (fld >= ADDR_EXT_BASE);
        if (kind != PBSL_NONE) begin
            next_st.sub_return = instr[RET_BIT];
        end
        case (kind)
            PBSL_FETCH: begin
                next_st.bus_rd          = 1'b1;
                next_st.stack_push      = 1'b1;
                next_st.stack_push_data = st.next;
                next_st.next            = st.top;
                if (instr[11:9] == OP_PLAIN) begin
                    next_st.top = rd_val;
                end else begin
                    next_st.top = alu_result;
                end
            end
            PBSL_STORE: begin
                next_st.bus_wdata = st.top;
                if (fld == ADDR_SEL_DATA && !inv) begin
                    next_st.page_select_bit = 1'b1;
                end else if (fld == ADDR_SEL_CODE && !inv) begin
                    next_st.page_select_bit = 1'b0;
                end else if (fld == ADDR_SWI_SET && !inv) begin
                    next_st.soft_irq_request = 1'b1;
                end else if (fld == ADDR_SWI_CLR && !inv) begin
                    next_st.soft_irq_request = 1'b0;
                end else begin
                    next_st.bus_wr = 1'b1;
                    if (inv) begin
                        next_st.top = ~st.top;
                    end
                end
            end
            PBSL_POP: begin
                next_st.bus_wr    = 1'b1;
                next_st.bus_wdata = st.top;
                next_st.top       = inv ? ~st.next : st.next;
                next_st.next      = stack_pop_data;
                next_st.stack_pop = 1'b1;
            end
            PBSL_DROP: begin
                next_st.bus_rd = 1'b1;
                if (inv) begin
                    next_st.top = ~st.top;
                end
            end
            PBSL_READ_ALU: begin
                next_st.bus_rd = 1'b1;
                next_st.top    = alu_result;
            end
            PBSL_LIT: begin
                next_st.stack_push      = 1'b1;
                next_st.stack_push_data = st.next;
                next_st.next            = st.top;
                if (instr[11:9] == OP_PLAIN) begin
                    next_st.top = lit_val;
                end else begin
                    next_st.top = alu_result;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign top              = st.top;
    assign next             = st.next;
    assign bus_addr         = st.bus_addr;
    assign bus_wdata        = st.bus_wdata;
    assign bus_rd           = st.bus_rd;
    assign bus_wr           = st.bus_wr;
    assign bus_ext          = st.bus_ext;
    assign stack_push       = st.stack_push;
    assign stack_push_data  = st.stack_push_data;
    assign stack_pop        = st.stack_pop;
    assign sub_return       = st.sub_return;
    assign page_select_bit  = st.page_select_bit;
    assign soft_irq_request = st.soft_irq_request;
    assign soft_irq_level   = SWI_LEVEL;

    // ***********************************************************
    // checks
    // ***********************************************************
    page_data_a: assert property (@(posedge clk) disable iff (rst)
        (kind == PBSL_STORE && fld == ADDR_SEL_DATA && !inv) |=> page_select_bit)
        else $error("data page select did not set page bit");
    page_code_a: assert property (@(posedge clk) disable iff (rst)
        (kind == PBSL_STORE && fld == ADDR_SEL_CODE && !inv) |=> !page_select_bit)
        else $error("code page select did not clear page bit");
    swi_set_a: assert property (@(posedge clk) disable iff (rst)
        (kind == PBSL_STORE && fld == ADDR_SWI_SET && !inv) |=> soft_irq_request)
        else $error("software interrupt not raised");
    swi_clr_a: assert property (@(posedge clk) disable iff (rst)
        (kind == PBSL_STORE && fld == ADDR_SWI_CLR && !inv) |=> !soft_irq_request)
        else $error("software interrupt not cleared");
    lit_push_a: assert property (@(posedge clk) disable iff (rst)
        (kind == PBSL_LIT && instr[11:9] == OP_PLAIN)
        |=> top == $past(lit_val) && next == $past(st.top) && stack_push)
        else $error("literal push wrong");
    fetch_push_a: assert property (@(posedge clk) disable iff (rst)
        (kind == PBSL_FETCH && instr[11:9] == OP_PLAIN)
        |=> bus_rd && stack_push && stack_push_data == $past(st.next))
        else $error("pushing fetch wrong");
    pop_store_a: assert property (@(posedge clk) disable iff (rst)
        (kind == PBSL_POP)
        |=> bus_wr && stack_pop && bus_wdata == $past(st.top)
            && top == ($past(inv) ? ~$past(st.next) : $past(st.next)))
        else $error("popping store wrong");
    read_op_a: assert property (@(posedge clk) disable iff (rst)
        (kind == PBSL_READ_ALU)
        |=> top == $past(alu_result) && $stable(next) && !stack_push)
        else $error("read with operation wrong");
    drop_read_a: assert property (@(posedge clk) disable iff (rst)
        (kind == PBSL_DROP)
        |=> bus_rd && !stack_push && $stable(next)
            && top == ($past(inv) ? ~$past(st.top) : $past(st.top)))
        else $error("dataless read wrong");

endmodule

`default_nettype wire

// ### verification/pbsl_periph_model.sv
// pbsl_periph_model: behavioural peripheral registers and stand-in alu
// assumes: read data follows the address field of the instruction in flight
`timescale 1ns/100ps
`default_nettype none
module pbsl_periph_model
    import pbsl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [4:0]  cur_addr,
    input  wire logic [4:0]  bus_addr,
    input  wire logic [15:0] bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic [15:0] alu_a,
    input  wire logic [15:0] alu_b,
    input  wire logic [3:0]  alu_func,
    output logic      [15:0] bus_rdata,
    output logic      [15:0] alu_result
);
    logic [15:0] mem [32];

    // ***********************************************************
    // register file
    // ***********************************************************
    // 32 locations
    initial begin
        for (int i = 0; i < 32; i++) begin
            mem[i] = 16'h5a00 + 16'(i);
        end
    end
    // a write lands at the edge after the strobe, so a read right behind it sees old data
    always @(posedge clk) begin
        if (bus_wr) begin
            mem[bus_addr] <= bus_wdata;
        end
    end
    assign bus_rdata = mem[cur_addr];

    // ***********************************************************
    // alu stand-in
    // ***********************************************************
    // function dependent result
    assign alu_result = alu_a ^ alu_b ^ {12'h000, alu_func};
endmodule
`default_nettype wire

// ### verification/peripheral_bus_and_short_literal_exec_tb.sv
// testbench: row table of back-to-back instructions, then reset and refusals
// assumes: outputs registered at the taking edge, checked at the negedge after it
`timescale 1ns/100ps
`default_nettype none
module peripheral_bus_and_short_literal_exec_tb;
    import pbsl_pkg::*;
    logic clk, rst, instr_valid;
    logic [15:0] instr, bus_rdata, alu_result, top, next, alu_a, alu_b, bus_wdata, push_d;
    logic [3:0]  alu_func, irq_lvl;
    logic [4:0]  bus_addr;
    logic bus_rd, bus_wr, bus_ext, push, pop, ret, page, irq;
    int bad_count, n_checks;
    logic [15:0] exp_next_prev;
    logic [15:0] exp_top_prev;
    typedef struct { logic [15:0] ins; logic [15:0] t; logic [15:0] n; logic [7:0] f; } pbsl_row_t;
    // flags: push pop rd wr ext page irq ret
    pbsl_row_t rows [18] = '{
        '{16'hb065, 16'h0005, 16'h0000, 8'h81},
        '{16'hb15f, 16'hffe0, 16'h0005, 8'h80},
        '{16'hb003, 16'h5a03, 16'hffe0, 8'ha0},
        '{16'hb104, 16'ha5fb, 16'h5a03, 8'ha0},
        '{16'hb201, 16'hfff8, 16'ha5fb, 8'ha0},
        '{16'hb243, 16'hfff9, 16'hfff8, 8'h80},
        '{16'hb291, 16'ha5ea, 16'hfff8, 8'h20},
        '{16'hb094, 16'ha5ea, 16'hfff8, 8'h10},
        '{16'hb3d4, 16'h5a15, 16'hfff8, 8'h20},
        '{16'hb014, 16'ha5ea, 16'h5a15, 8'ha0},
        '{16'hb041, 16'h0001, 16'ha5ea, 8'h80},
        '{16'hb0da, 16'ha5ea, 16'hc3c3, 8'h58},
        '{16'hb08e, 16'ha5ea, 16'hc3c3, 8'h04},
        '{16'hb08b, 16'ha5ea, 16'hc3c3, 8'h06},
        '{16'h0000, 16'ha5ea, 16'hc3c3, 8'h06},
        '{16'h0000, 16'ha5ea, 16'hc3c3, 8'h06},
        '{16'hb08c, 16'ha5ea, 16'hc3c3, 8'h04},
        '{16'hb08d, 16'ha5ea, 16'hc3c3, 8'h00}
    };

    pbsl_exec uut (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
        .bus_rdata(bus_rdata), .alu_result(alu_result), .stack_pop_data(16'hc3c3),
        .top(top), .next(next), .alu_a(alu_a), .alu_b(alu_b), .alu_func(alu_func),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_wr(bus_wr),
        .bus_ext(bus_ext), .stack_push(push), .stack_push_data(push_d), .stack_pop(pop),
        .sub_return(ret), .page_select_bit(page), .soft_irq_request(irq),
        .soft_irq_level(irq_lvl));
    pbsl_periph_model far (.clk(clk), .cur_addr(instr[4:0]), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .alu_a(alu_a), .alu_b(alu_b),
        .alu_func(alu_func), .bus_rdata(bus_rdata), .alu_result(alu_result));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask

    task automatic end_of_test();
        if (bad_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check_row(input pbsl_row_t r);
        chk16(top, r.t);
        chk16(next, r.n);
        chk16({push, pop, bus_rd, bus_wr, page, irq, ret}, {r.f[7:4], r.f[2:0]});
        if (r.f[7]) chk16(push_d, exp_next_prev);
        if (r.f[5] | r.f[4]) chk16({bus_ext, bus_addr}, {r.f[3], r.ins[4:0]});
        if (r.f[4]) chk16(bus_wdata, exp_top_prev);
        exp_next_prev = r.n;
        exp_top_prev = r.t;
    endtask

    initial begin
        #(100 * 200);
        bad_count++;
        end_of_test();
    end

    initial begin
        bad_count = 0;
        n_checks = 0;
        exp_next_prev = 16'h0000;
        exp_top_prev = 16'h0000;
        rst = 1'b1;
        instr_valid = 1'b0;
        instr = 16'h0000;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        // ***********************************************************
        // ordinary rows, issued back to back
        // ***********************************************************
        for (int i = 0; i < 18; i++) begin
            @(posedge clk);
            instr <= rows[i].ins;
            instr_valid <= 1'b1;
            @(negedge clk);
            if (i > 0) check_row(rows[i - 1]);
        end
        @(posedge clk);
        instr_valid <= 1'b0;
        @(negedge clk);
        check_row(rows[17]);
        chk16({12'h000, irq_lvl}, 16'h000d);
        // ***********************************************************
        // refusals and a reset in mid-run
        // ***********************************************************
        @(posedge clk);
        instr <= 16'hb08b;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk1(irq, 1'b0);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= 16'hc045;
        @(posedge clk);
        instr <= 16'hb08e;
        @(negedge clk);
        chk16(top, 16'ha5ea);
        @(posedge clk);
        instr <= 16'hb08b;
        rst <= 1'b1;
        @(negedge clk);
        chk1(page, 1'b1);
        @(posedge clk);
        rst <= 1'b0;
        instr_valid <= 1'b0;
        @(negedge clk);
        chk16(top, 16'h0000);
        chk1(page, 1'b0);
        chk1(irq, 1'b0);
        end_of_test();
    end
endmodule
`default_nettype wire
